// file: design/prio_resolver.sv
`timescale 1ns/1ps
module prio_resolver
  import vic_pkg::*;
(
  // Candidates and their priorities
  input  wire vic_pkg::src_vec_t  cand_i,
  input  wire logic [95:0]        prio_flat_i,
  // Winner
  output vic_pkg::src_id_t        best_id_o,
  output vic_pkg::prio_t          best_lvl_o,
  output logic                    any_o
);
  // Scan downward so ties settle on the lowest number
  always_comb
  begin
    best_id_o  = '0;
    best_lvl_o = '0;
    any_o      = 1'b0;
    for (int i = 31; i >= 1; i--)
    begin
      if (cand_i[i] && (!any_o || prio_flat_i[i*3 +: 3] >= best_lvl_o))
      begin
        best_id_o  = src_id_t'(i);
        best_lvl_o = prio_flat_i[i*3 +: 3];
        any_o      = 1'b1;
      end
    end
  end
endmodule // prio_resolver

// file: design/src_input_stage.sv
`timescale 1ns/1ps
module src_input_stage
  import vic_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Raw sources and their mode
  input  wire vic_pkg::src_vec_t  src_i,
  input  wire vic_pkg::src_vec_t  edge_mode_i,
  input  wire vic_pkg::src_vec_t  pol_high_i,
  // Software and hardware clear/set of edge memory
  input  wire vic_pkg::src_vec_t  set_i,
  input  wire vic_pkg::src_vec_t  clr_i,
  // Pending image
  output vic_pkg::src_vec_t       pend_o
);
  src_vec_t s1_r, s2_r, s3_r, filt_r, act_prev_r, edge_mem_r;
  src_vec_t act;

  // Three-stage synchroniser
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= src_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      filt_r <= '0;
    else
      filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
  end

  // Active level per polarity
  assign act = ~(filt_r ^ pol_high_i);

  // Previous active level for edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      act_prev_r <= '0;
    else
      act_prev_r <= act;
  end

  // Edge memory; a new edge or set wins over a clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      edge_mem_r <= '0;
    else
      edge_mem_r <= edge_mode_i & ((edge_mem_r & ~clr_i) | set_i
                    | (act & ~act_prev_r));
  end

  // Level sources follow the input; edge sources use memory
  assign pend_o = (edge_mode_i & edge_mem_r) | (~edge_mode_i & act);
endmodule // src_input_stage

// file: design/vic_defs.svh
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH

// Sources and nesting depth
`define VIC_NSRC          32
`define VIC_STACK_DEPTH   8
`define VIC_DEPTH_W       4

// Word-address regions (byte address bits [11:7])
`define VIC_REGION_MODE   5'h00
`define VIC_REGION_HANDLR 5'h01

// Byte offsets of single registers
`define VIC_OFF_VECTOR    12'h100
`define VIC_OFF_CUR_ID    12'h108
`define VIC_OFF_PENDING   12'h10c
`define VIC_OFF_MASK      12'h110
`define VIC_OFF_CORE_STAT 12'h114
`define VIC_OFF_DEPTH     12'h118
`define VIC_OFF_EN_SET    12'h120
`define VIC_OFF_EN_CLR    12'h124
`define VIC_OFF_PEND_CLR  12'h128
`define VIC_OFF_PEND_SET  12'h12c
`define VIC_OFF_EOS       12'h130
`define VIC_OFF_SPURIOUS  12'h134
`define VIC_OFF_FF_SET    12'h140
`define VIC_OFF_FF_CLR    12'h144
`define VIC_OFF_FF_STAT   12'h148

// Source mode fields
`define VIC_PRIO_LSB      0
`define VIC_PRIO_MSB      2
`define VIC_TYPE_LSB      5
`define VIC_TYPE_MSB      6

// Reset values
`define VIC_RST_SPURIOUS  32'h0000_0000
`define VIC_RST_ZERO32    32'h0000_0000

`endif

// file: design/vic_normal_irq.sv
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "vic_defs.svh"
module vic_normal_irq
  import vic_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [11:0]        adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic [31:0]             dat_o,
  output logic                    ack_o,
  // Interrupt sources and request to the core
  input  wire vic_pkg::src_vec_t  src_i,
  output logic                    irq_request_n_o
);
  typedef logic [`VIC_DEPTH_W-1:0] depth_t;

  prio_t       prio_r    [`VIC_NSRC];
  trig_t       type_r    [`VIC_NSRC];
  logic [31:0] handler_r [`VIC_NSRC];
  src_id_t     stk_id_r  [`VIC_STACK_DEPTH];
  prio_t       stk_lvl_r [`VIC_STACK_DEPTH];
  src_vec_t    enable_r, ffe_r, edge_mode, pol_high, pend, cand;
  src_vec_t    set_cmd, clr_cmd;
  logic [31:0] spur_r, rdata, vec_pick;
  logic [95:0] prio_flat;
  src_id_t     cur_id_r, best_id;
  prio_t       cur_lvl_r, best_lvl;
  depth_t      depth_r;
  logic        any, ack_r, take, wr, rd, vec_hit, eos_hit, irq_cond;
  logic        in_mode, in_hdl;
  logic [4:0]  widx;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    for (int b = 0; b < 4; b++)
      merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
  endfunction

  // Full-word command write at a given offset
  function automatic logic cmd_hit(input logic        w,
                                   input logic [11:0] a,
                                   input logic [11:0] off);
    return w && a[11:2] == off[11:2];
  endfunction

  // Bus decode, one-cycle answer
  assign take    = cyc_i & stb_i & ~ack_r;
  assign wr      = take & we_i;
  assign rd      = take & ~we_i;
  assign widx    = adr_i[6:2];
  assign in_mode = adr_i[11:7] == `VIC_REGION_MODE;
  assign in_hdl  = adr_i[11:7] == `VIC_REGION_HANDLR;
  assign vec_hit = rd && adr_i[11:2] == `VIC_OFF_VECTOR >> 2;
  assign eos_hit = cmd_hit(wr, adr_i, `VIC_OFF_EOS);
  assign ack_o   = ack_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= take;
  end

  // Mode and handler registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < `VIC_NSRC; i++)
      begin
        prio_r[i]    <= '0;
        type_r[i]    <= TRIG_LOW_LEVEL;
        handler_r[i] <= `VIC_RST_ZERO32;
      end
    end
    else if (wr && in_mode && sel_i[0])
    begin
      prio_r[widx] <= dat_i[`VIC_PRIO_MSB:`VIC_PRIO_LSB];
      type_r[widx] <= trig_t'(dat_i[`VIC_TYPE_MSB:`VIC_TYPE_LSB]);
    end
    else if (wr && in_hdl)
      handler_r[widx] <= merge(handler_r[widx], dat_i, sel_i);
  end

  // Enable mask, redirection mask and spurious vector
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable_r <= '0;
      ffe_r    <= '0;
      spur_r   <= `VIC_RST_SPURIOUS;
    end
    else
    begin
      if (cmd_hit(wr, adr_i, `VIC_OFF_EN_SET))
        enable_r <= enable_r | dat_i;
      if (cmd_hit(wr, adr_i, `VIC_OFF_EN_CLR))
        enable_r <= enable_r & ~dat_i;
      if (cmd_hit(wr, adr_i, `VIC_OFF_FF_SET))
        ffe_r <= ffe_r | dat_i;
      if (cmd_hit(wr, adr_i, `VIC_OFF_FF_CLR))
        ffe_r <= ffe_r & ~dat_i;
      if (cmd_hit(wr, adr_i, `VIC_OFF_SPURIOUS))
        spur_r <= merge(spur_r, dat_i, sel_i);
    end
  end

  // Per-source mode decode
  always_comb
  begin
    for (int i = 0; i < `VIC_NSRC; i++)
    begin
      edge_mode[i]       = type_r[i][0];
      pol_high[i]        = type_r[i][1];
      prio_flat[i*3 +: 3] = prio_r[i];
    end
  end

  // Set/clear commands; vector read clears an edge winner
  always_comb
  begin
    set_cmd = cmd_hit(wr, adr_i, `VIC_OFF_PEND_SET) ? dat_i : '0;
    clr_cmd = cmd_hit(wr, adr_i, `VIC_OFF_PEND_CLR) ? dat_i : '0;
    if (vec_hit && any)
      clr_cmd[best_id] = 1'b1;
  end

  src_input_stage u_inputs (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .src_i       (src_i),
    .edge_mode_i (edge_mode),
    .pol_high_i  (pol_high),
    .set_i       (set_cmd),
    .clr_i       (clr_cmd),
    .pend_o      (pend)
  );

  // Candidates: enabled, not redirected, not source 0
  assign cand = pend & enable_r & ~ffe_r & ~src_vec_t'(1);

  prio_resolver u_resolver (
    .cand_i      (cand),
    .prio_flat_i (prio_flat),
    .best_id_o   (best_id),
    .best_lvl_o  (best_lvl),
    .any_o       (any)
  );

  assign vec_pick = handler_r[best_id];

  // Nesting stack and current interrupt
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      depth_r   <= '0;
      cur_id_r  <= '0;
      cur_lvl_r <= '0;
      for (int i = 0; i < `VIC_STACK_DEPTH; i++)
      begin
        stk_id_r[i]  <= '0;
        stk_lvl_r[i] <= '0;
      end
    end
    else if (vec_hit && any && depth_r < depth_t'(`VIC_STACK_DEPTH))
    begin
      stk_id_r[depth_r[2:0]]  <= cur_id_r;
      stk_lvl_r[depth_r[2:0]] <= cur_lvl_r;
      depth_r   <= depth_r + depth_t'(1);
      cur_id_r  <= best_id;
      cur_lvl_r <= best_lvl;
    end
    else if (eos_hit && depth_r != '0)
    begin
      depth_r   <= depth_r - depth_t'(1);
      cur_id_r  <= stk_id_r[3'(depth_r - depth_t'(1))];
      cur_lvl_r <= stk_lvl_r[3'(depth_r - depth_t'(1))];
    end
  end

  // Request condition against the current level
  assign irq_cond = any && (depth_r == '0 || best_lvl > cur_lvl_r);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_request_n_o <= 1'b1;
    else if (vec_hit || eos_hit)
      irq_request_n_o <= 1'b1;
    else
      irq_request_n_o <= ~irq_cond;
  end

  // Read mux
  always_comb
  begin
    rdata = '0;
    if (in_mode)
      rdata = {25'h0, 1'(type_r[widx] >> 1), 1'(type_r[widx]), 2'h0,
               prio_r[widx]};
    else if (in_hdl)
      rdata = handler_r[widx];
    else
      case (adr_i[11:2])
        `VIC_OFF_VECTOR >> 2:    rdata = any ? vec_pick : spur_r;
        `VIC_OFF_CUR_ID >> 2:    rdata = {27'h0, cur_id_r};
        `VIC_OFF_PENDING >> 2:   rdata = pend;
        `VIC_OFF_MASK >> 2:      rdata = enable_r;
        `VIC_OFF_CORE_STAT >> 2: rdata = {31'h0, ~irq_request_n_o};
        `VIC_OFF_DEPTH >> 2:     rdata = {28'h0, depth_r};
        `VIC_OFF_SPURIOUS >> 2:  rdata = spur_r;
        `VIC_OFF_FF_STAT >> 2:   rdata = ffe_r;
        default:                 rdata = '0;
      endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= '0;
    else if (rd)
      dat_o <= rdata;
  end

  // Checks
  property p_irq_idle;
    @(posedge clk_i) disable iff (rst_i)
      (depth_r == '0 && any && !vec_hit && !eos_hit) |=> !irq_request_n_o;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("no request");

  property p_vec_deassert;
    @(posedge clk_i) disable iff (rst_i) vec_hit |=> irq_request_n_o;
  endproperty
  a_vec_deassert: assert property (p_vec_deassert)
    else $error("request after vector read");

  property p_push;
    @(posedge clk_i) disable iff (rst_i)
      (vec_hit && any && depth_r < 4'd8) |=>
        depth_r == $past(depth_r) + 4'd1 && cur_lvl_r == $past(best_lvl);
  endproperty
  a_push: assert property (p_push) else $error("push failed");

  property p_take_best;
    @(posedge clk_i) disable iff (rst_i)
      (vec_hit && any && depth_r < 4'd8) |=> cur_id_r == $past(best_id);
  endproperty
  a_take_best: assert property (p_take_best) else $error("wrong winner");

  property p_pop;
    @(posedge clk_i) disable iff (rst_i)
      (eos_hit && depth_r != '0 && !vec_hit) |=>
        depth_r == $past(depth_r) - 4'd1;
  endproperty
  a_pop: assert property (p_pop) else $error("pop failed");

  property p_depth_bound;
    @(posedge clk_i) disable iff (rst_i) depth_r <= 4'd8;
  endproperty
  a_depth_bound: assert property (p_depth_bound) else $error("overflow");

  property p_spurious;
    @(posedge clk_i) disable iff (rst_i)
      (vec_hit && !any) |=> dat_o == $past(spur_r) && $stable(depth_r);
  endproperty
  a_spurious: assert property (p_spurious) else $error("bad spurious");

  property p_vector;
    @(posedge clk_i) disable iff (rst_i)
      (vec_hit && any) |=> dat_o == $past(vec_pick);
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector");

  property p_hold_low;
    @(posedge clk_i) disable iff (rst_i)
      (depth_r != '0 && !(any && best_lvl > cur_lvl_r)) |=> irq_request_n_o;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("early request");

  property p_src0_out;
    @(posedge clk_i) disable iff (rst_i) any |-> best_id != '0;
  endproperty
  a_src0_out: assert property (p_src0_out) else $error("source 0 won");

  c_nested: cover property (@(posedge clk_i) disable iff (rst_i)
    depth_r == 4'd2);
  c_spur: cover property (@(posedge clk_i) disable iff (rst_i)
    vec_hit && !any);
  c_reassert: cover property (@(posedge clk_i) disable iff (rst_i)
    eos_hit ##1 !irq_request_n_o);
endmodule // vic_normal_irq

// file: design/vic_pkg.sv
package vic_pkg;
  // Trigger type, field value 0..3 in this order
  typedef enum logic [1:0] {
    TRIG_LOW_LEVEL,
    TRIG_FALL_EDGE,
    TRIG_HIGH_LEVEL,
    TRIG_RISE_EDGE
  } trig_t;
  typedef logic [2:0]  prio_t;
  typedef logic [4:0]  src_id_t;
  typedef logic [31:0] src_vec_t;
endpackage

// file: tb/core_model.sv
`timescale 1ns/1ps
module core_model
(
  // Clock
  input  wire logic        clk_i,
  // Wishbone master side
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [11:0]      adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i
);
  // Idle bus at time zero
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 12'h000;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // One classic cycle, held until ack, bounded wait
  task automatic access(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic ok);
    int n;
    begin
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      sel_o <= 4'hf;
      dat_o <= d;
      n = 0;
      do
      begin
        @(posedge clk_i);
        n++;
      end
      while (ack_i !== 1'b1 && n < 16);
      ok = (ack_i === 1'b1);
      r = dat_i;
      // Release; stale lines must not look valid
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      adr_o <= ~a;
      dat_o <= ~d;
    end
  endtask
endmodule // core_model

// file: tb/vic_normal_irq_bench.sv
`timescale 1ns/1ps
module vic_normal_irq_bench;
  import vic_pkg::*;
  typedef struct { int a; int pa; int b; int pb; int w; } row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, irq_n;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  src_vec_t    src = '0;
  int          errors = 0;
  int          tests_run = 0;
  // Two sources, their priorities, expected winner
  row_t rows [5] = '{'{5, 3, 9, 6, 9}, '{4, 2, 7, 2, 4},
    '{0, 7, 12, 1, 12}, '{31, 7, 1, 0, 31}, '{3, 0, 30, 0, 3}};

  // Clock
  always #5 clk_i = ~clk_i;

  vic_normal_irq vic_normal_irq_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .src_i(src), .irq_request_n_o(irq_n));

  core_model core_model_inst (
    .clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

  // Compare and report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Bus access through the core model
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    logic ok;
    core_model_inst.access(w, a, d, r, ok);
    if (ok !== 1'b1)
    begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  task automatic mode(input int n, input trig_t t, input int p);
    wr(12'(4 * n), {25'h0, t, 2'b00, 3'(p)});
  endtask

  // Bounded wait for the request
  task automatic waitirq();
    int n;
    n = 0;
    while (irq_n !== 1'b0 && n < 30)
    begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, irq_n}, 32'h0);
    if (n == 30)
      print_verdict();
  endtask

  function automatic logic [31:0] hv(input int n);
    return 32'h0001_0000 + 32'(n) * 32'h10;
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    logic [31:0] r;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({31'h0, irq_n}, 32'h1);
    rd(12'h118, 32'h0);
    rd(12'h1fc, 32'h0);
    for (int n = 0; n < 32; n++)
    begin
      wr(12'h080 + 12'(4 * n), hv(n));
      mode(n, TRIG_HIGH_LEVEL, 0);
    end
    wr(12'h120, 32'hffff_ffff);
    foreach (rows[i])
    begin
      mode(rows[i].a, TRIG_HIGH_LEVEL, rows[i].pa);
      mode(rows[i].b, TRIG_HIGH_LEVEL, rows[i].pb);
      src <= (32'h1 << rows[i].a) | (32'h1 << rows[i].b);
      waitirq();
      rd(12'h100, hv(rows[i].w));
      repeat (4) @(posedge clk_i);
      chk({31'h0, irq_n}, 32'h1);
      bus(1'b0, 12'h10c, 32'h0, r);
      chk(32'(r[rows[i].w]), 32'h1);
      src <= '0;
      repeat (8) @(posedge clk_i);
      wr(12'h130, 32'h0);
      rd(12'h118, 32'h0);
      $display("row %0d done", i);
    end
    // Nothing pending gives the spurious vector
    wr(12'h134, 32'h0000_5a5a);
    rd(12'h100, 32'h0000_5a5a);
    rd(12'h118, 32'h0);
    $display("spurious done");
    // Masked and redirected sources stay out
    wr(12'h124, 32'h0010_0000);
    wr(12'h140, 32'h0000_2000);
    mode(20, TRIG_HIGH_LEVEL, 7);
    mode(13, TRIG_RISE_EDGE, 7);
    mode(14, TRIG_HIGH_LEVEL, 1);
    src <= 32'h0010_6000;
    waitirq();
    rd(12'h100, hv(14));
    bus(1'b0, 12'h10c, 32'h0, r);
    chk(32'(r[13]), 32'h1);
    src <= '0;
    repeat (8) @(posedge clk_i);
    wr(12'h130, 32'h0);
    wr(12'h128, 32'h0000_2000);
    wr(12'h144, 32'h0000_2000);
    wr(12'h120, 32'h0010_0000);
    $display("mask and redirect done");
    // Edge memory cleared by the vector read
    mode(8, TRIG_RISE_EDGE, 4);
    src <= 32'h0000_0100;
    repeat (4) @(posedge clk_i);
    src <= '0;
    waitirq();
    rd(12'h100, hv(8));
    bus(1'b0, 12'h10c, 32'h0, r);
    chk(32'(r[8]), 32'h0);
    wr(12'h130, 32'h0);
    repeat (4) @(posedge clk_i);
    chk({31'h0, irq_n}, 32'h1);
    $display("edge clear done");
    // Eight nested levels, one read beyond, pop with reassert
    for (int k = 1; k <= 8; k++)
      mode(k, TRIG_HIGH_LEVEL, k - 1);
    for (int k = 1; k <= 8; k++)
    begin
      src[k] <= 1'b1;
      waitirq();
      rd(12'h100, hv(k));
    end
    rd(12'h118, 32'h8);
    rd(12'h100, hv(8));
    rd(12'h118, 32'h8);
    wr(12'h130, 32'h0);
    waitirq();
    rd(12'h100, hv(8));
    src <= '0;
    repeat (8) @(posedge clk_i);
    repeat (8) wr(12'h130, 32'h0);
    rd(12'h118, 32'h0);
    $display("nesting done");
    // Reset in mid-service
    src[3] <= 1'b1;
    waitirq();
    rd(12'h100, hv(3));
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    src <= '0;
    chk({31'h0, irq_n}, 32'h1);
    rd(12'h118, 32'h0);
    $display("second reset done");
    print_verdict();
  end
endmodule // vic_normal_irq_bench
